/* File: hw/dspmx_top.sv */
// pin-function mux, mode capture, host port and apb registers
`timescale 1ns/100ps
module dspmx_top (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // general i/o pins, mode pins on bits 2:0
    input wire logic [7:0] gp_io_in,
    output logic [7:0] gp_io_out,
    output logic [7:0] gp_io_oe_n,
    // serial port 1 pins
    input wire logic sp1_rfs_in,
    input wire logic sp1_tfs_in,
    input wire logic sp1_dr_in,
    output logic sp1_dt_out,
    input wire logic core_sp1_dt,
    output logic core_sp1_dr,
    // core side
    input wire dspmx_pkg::dspmx_mem_req_t core_req,
    output logic [23:0] core_rdata,
    output logic [5:0] irq_req,
    output logic host_mode,
    // external memory bus
    output logic [13:0] ext_addr_out,
    input wire logic [23:0] ext_data_in,
    output logic [23:0] ext_data_out,
    output logic [23:0] ext_data_oe_n,
    output logic ext_bus_oe_n,
    output logic data_space_sel_n,
    output logic prog_space_sel_n,
    output logic byte_space_sel_n,
    output logic io_space_sel_n,
    output logic combined_sel_n,
    output logic mem_rd_n,
    output logic mem_wr_n,
    // bus arbitration
    input wire logic bus_req_n,
    output logic bus_grant_n,
    output logic bus_grant_hung_n,
    // host memory access port
    input wire logic [15:0] host_port_ad_in,
    output logic [15:0] host_port_ad_out,
    output logic [15:0] host_port_ad_oe_n,
    input wire logic host_addr_latch,
    input wire logic host_port_sel_n,
    input wire logic host_rd_en_n,
    input wire logic host_wr_en_n,
    output logic host_port_ack_n,
    // power down
    input wire logic powerdown_req,
    output logic powerdown_ack
);
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == dspmx_pkg::OFS_CTRL) || (a == dspmx_pkg::OFS_GPIO_DIR) ||
                  (a == dspmx_pkg::OFS_GPIO_OUT) || (a == dspmx_pkg::OFS_GPIO_IN) ||
                  (a == dspmx_pkg::OFS_INTERRUPT_MASK_REG) || (a == dspmx_pkg::OFS_IRQ_PEND) ||
                  (a == dspmx_pkg::OFS_STATUS);
    endfunction

    function automatic logic [3:0] space_dec(input dspmx_pkg::dspmx_space_t s);
        space_dec = 4'h1 << s;
    endfunction

    // ---------------- registers, gpio and interrupts
    logic [11:0] ctrl_q, ctrl_d;
    logic [8:0] gp_dir_q, gp_dir_d, gp_out_q, gp_out_d;
    logic [5:0] interrupt_mask_reg_q, interrupt_mask_reg_d, irq_pend_q, irq_pend_d, irq_prev_q, irq_prev_d, irq_req_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, wr_en;
    logic [7:0] gp_io_out_d, gp_io_oe_n_d, gp_eff;
    logic [5:0] src_n, is_edge, w1c;
    logic sp1_dt_out_d, core_sp1_dr_d;
    logic mode_valid_q, mode_valid_d, granted_q, granted_d, pd_q, pd_d;
    logic [2:0] mode_q, mode_d;

    assign wr_en = psel && penable && pready && pwrite;
    assign gp_eff = (gp_dir_q[7:0] & gp_out_q[7:0]) | (~gp_dir_q[7:0] & gp_io_in);
    always_comb begin
        src_n = {sp1_tfs_in, sp1_rfs_in, gp_eff[7:4]};
        // serial interrupts idle high unless the alternate pin role is on
        if (!ctrl_q[dspmx_pkg::CTRL_SP1_ALT]) begin
            src_n[5:4] = 2'h3;
        end
        if (!mode_valid_q) begin
            src_n = 6'h3f;
        end
    end
    assign is_edge = {ctrl_q[dspmx_pkg::CTRL_SPIRQ1_EDGE], ctrl_q[dspmx_pkg::CTRL_SPIRQ0_EDGE],
                      ctrl_q[dspmx_pkg::CTRL_IRQ7_EDGE], 3'h1};
    assign w1c = (wr_en && paddr == dspmx_pkg::OFS_IRQ_PEND) ? pwdata[5:0] : 6'h00;

    // set beats a same-cycle software clear
    for (genvar i = 0; i < dspmx_pkg::N_IRQ; i++) begin : g_irq
        always_comb begin
            if (is_edge[i]) begin
                irq_pend_d[i] = (irq_prev_q[i] && !src_n[i]) || (irq_pend_q[i] && !w1c[i]);
            end else begin
                irq_pend_d[i] = !src_n[i];
            end
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        gp_dir_d = gp_dir_q;
        gp_out_d = gp_out_q;
        interrupt_mask_reg_d = interrupt_mask_reg_q;
        irq_prev_d = src_n;
        irq_req_d = irq_pend_d & interrupt_mask_reg_q;
        pready_d = psel && !penable;
        pslverr_d = psel && !penable && !reg_hit(paddr);
        prdata_d = prdata;
        if (psel && !penable) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                dspmx_pkg::OFS_CTRL: prdata_d[11:0] = ctrl_q;
                dspmx_pkg::OFS_GPIO_DIR: prdata_d[8:0] = gp_dir_q;
                dspmx_pkg::OFS_GPIO_OUT: prdata_d[8:0] = gp_out_q;
                dspmx_pkg::OFS_GPIO_IN: prdata_d[8:0] = {sp1_dr_in, gp_io_in};
                dspmx_pkg::OFS_INTERRUPT_MASK_REG: prdata_d[5:0] = interrupt_mask_reg_q;
                dspmx_pkg::OFS_IRQ_PEND: prdata_d[5:0] = irq_pend_q;
                dspmx_pkg::OFS_STATUS: prdata_d[6:0] = {mode_q, mode_valid_q, pd_q, granted_q, host_mode};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            unique case (paddr)
                dspmx_pkg::OFS_CTRL: ctrl_d = pwdata[11:0];
                dspmx_pkg::OFS_GPIO_DIR: gp_dir_d = {1'b0, pwdata[7:0]};
                dspmx_pkg::OFS_GPIO_OUT: gp_out_d = pwdata[8:0];
                dspmx_pkg::OFS_INTERRUPT_MASK_REG: interrupt_mask_reg_d = pwdata[5:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
        // pins stay undriven until the mode straps have been taken
        gp_io_oe_n_d = mode_valid_q ? ~gp_dir_q[7:0] : 8'hff;
        gp_io_out_d = gp_out_q[7:0];
        sp1_dt_out_d = ctrl_q[dspmx_pkg::CTRL_SP1_ALT] ? gp_out_q[dspmx_pkg::GPOUT_FLAG_BIT] : core_sp1_dt;
        core_sp1_dr_d = ctrl_q[dspmx_pkg::CTRL_SP1_ALT] ? 1'b0 : sp1_dr_in;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= dspmx_pkg::CTRL_RST;
            gp_dir_q <= dspmx_pkg::GPIO_DIR_RST;
            gp_out_q <= dspmx_pkg::GPIO_OUT_RST;
            interrupt_mask_reg_q <= dspmx_pkg::INTERRUPT_MASK_REG_RST;
            irq_pend_q <= 6'h00;
            irq_prev_q <= 6'h3f;
            irq_req <= 6'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            gp_io_out <= 8'hff;
            gp_io_oe_n <= 8'hff;
            sp1_dt_out <= 1'b0;
            core_sp1_dr <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            gp_dir_q <= gp_dir_d;
            gp_out_q <= gp_out_d;
            interrupt_mask_reg_q <= interrupt_mask_reg_d;
            irq_pend_q <= irq_pend_d;
            irq_prev_q <= irq_prev_d;
            irq_req <= irq_req_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            gp_io_out <= gp_io_out_d;
            gp_io_oe_n <= gp_io_oe_n_d;
            sp1_dt_out <= sp1_dt_out_d;
            core_sp1_dr <= core_sp1_dr_d;
        end
    end

    // ---------------- mode capture, external bus, arbitration, power down
    logic acc, host_mode_d, pd_ok;
    logic [3:0] sel, sel_d;
    logic [13:0] ext_addr_d;
    logic [23:0] ext_dout_d, ext_oe_n_d, core_rdata_d, dmask;
    logic [2:0] mode_pins;
    logic [13:0] req_addr;
    dspmx_pkg::dspmx_space_t req_space;

    assign mode_pins = gp_io_in[2:0];
    assign req_addr = core_req.addr;
    assign req_space = core_req.space;
    assign acc = mode_valid_q && !granted_q && !pd_q && (core_req.rd || core_req.wr);
    assign sel = acc ? space_dec(core_req.space) : 4'h0;
    assign pd_ok = !(core_req.rd || core_req.wr) && !granted_q;

    always_comb begin
        // straps are taken on the first edge after reset release, then frozen
        mode_valid_d = 1'b1;
        mode_d = mode_valid_q ? mode_q : mode_pins;
        host_mode_d = mode_valid_q ? host_mode : mode_pins[dspmx_pkg::MODE_HOST_BIT];
        granted_d = granted_q;
        if (bus_req_n) begin
            granted_d = 1'b0;
        end else if (!(core_req.rd || core_req.wr)) begin
            granted_d = 1'b1;
        end
        pd_d = powerdown_req && (pd_q || pd_ok);
        sel_d = sel;
        dmask = host_mode ? 24'hffff00 : 24'hffffff;
        ext_addr_d = host_mode ? {13'h0000, core_req.addr[0]} : core_req.addr;
        ext_dout_d = core_req.wdata;
        ext_oe_n_d = 24'hffffff;
        if (acc && core_req.wr) begin
            ext_oe_n_d = ~dmask;
        end
        if (acc && !host_mode && core_req.space == dspmx_pkg::SP_BYTE) begin
            ext_dout_d[23:16] = core_req.baddr_hi;
            ext_oe_n_d[23:16] = 8'h00;
        end
        // read data is taken while the read strobe stands on the pins, not before it goes out
        core_rdata_d = !mem_rd_n ? (ext_data_in & dmask) : core_rdata;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_valid_q <= 1'b0;
            mode_q <= 3'h0;
            host_mode <= 1'b0;
            granted_q <= 1'b0;
            pd_q <= 1'b0;
            bus_grant_n <= 1'b1;
            bus_grant_hung_n <= 1'b1;
            ext_bus_oe_n <= 1'b1;
            powerdown_ack <= 1'b0;
            ext_addr_out <= 14'h0000;
            ext_data_out <= 24'h000000;
            ext_data_oe_n <= 24'hffffff;
            core_rdata <= 24'h000000;
            {io_space_sel_n, byte_space_sel_n, prog_space_sel_n, data_space_sel_n} <= 4'hf;
            combined_sel_n <= 1'b1;
            mem_rd_n <= 1'b1;
            mem_wr_n <= 1'b1;
        end else begin
            mode_valid_q <= mode_valid_d;
            mode_q <= mode_d;
            host_mode <= host_mode_d;
            granted_q <= granted_d;
            pd_q <= pd_d;
            bus_grant_n <= !granted_d;
            bus_grant_hung_n <= !(granted_d && (core_req.rd || core_req.wr));
            ext_bus_oe_n <= granted_d || !mode_valid_q;
            powerdown_ack <= pd_d;
            ext_addr_out <= ext_addr_d;
            ext_data_out <= ext_dout_d;
            ext_data_oe_n <= ext_oe_n_d;
            core_rdata <= core_rdata_d;
            {io_space_sel_n, byte_space_sel_n, prog_space_sel_n, data_space_sel_n} <= ~sel_d;
            combined_sel_n <= !(|(sel_d & ctrl_q[dspmx_pkg::CTRL_CMB_LSB +: 4]));
            mem_rd_n <= !(acc && core_req.rd);
            mem_wr_n <= !(acc && core_req.wr);
        end
    end

    // ---------------- host memory access port
    dspmx_pkg::dspmx_hp_state_t hp_state_q, hp_state_d;
    logic [5:0] hp_addr_q, hp_addr_d;
    logic [15:0] hp_out_d, hp_oe_n_d, ram_rdata;
    logic hp_ack_n_d, ram_we, hp_on;

    assign hp_on = host_mode && mode_valid_q && !host_port_sel_n;

    always_comb begin
        hp_state_d = hp_state_q;
        hp_addr_d = hp_addr_q;
        hp_out_d = host_port_ad_out;
        hp_oe_n_d = host_port_ad_oe_n;
        hp_ack_n_d = host_port_ack_n;
        ram_we = 1'b0;
        unique case (hp_state_q)
            dspmx_pkg::HP_IDLE: begin
                if (hp_on && host_addr_latch) begin
                    hp_addr_d = host_port_ad_in[5:0];
                end else if (hp_on && !host_rd_en_n) begin
                    hp_state_d = dspmx_pkg::HP_READ;
                end else if (hp_on && !host_wr_en_n) begin
                    ram_we = 1'b1;
                    hp_addr_d = hp_addr_q + 6'h01;
                    hp_ack_n_d = 1'b0;
                    hp_state_d = dspmx_pkg::HP_ACK;
                end
            end
            dspmx_pkg::HP_READ: begin
                hp_out_d = ram_rdata;
                hp_oe_n_d = 16'h0000;
                hp_ack_n_d = 1'b0;
                hp_addr_d = hp_addr_q + 6'h01;
                hp_state_d = dspmx_pkg::HP_ACK;
            end
            dspmx_pkg::HP_ACK: begin
                // hold the answer until the host lets go of its strobe or deselects the port
                if (!hp_on || (host_rd_en_n && host_wr_en_n)) begin
                    hp_ack_n_d = 1'b1;
                    hp_oe_n_d = 16'hffff;
                    hp_state_d = dspmx_pkg::HP_IDLE;
                end
            end
            default: begin
                hp_ack_n_d = 1'b1;
                hp_oe_n_d = 16'hffff;
                hp_state_d = dspmx_pkg::HP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hp_state_q <= dspmx_pkg::HP_IDLE;
            hp_addr_q <= 6'h00;
            host_port_ad_out <= 16'h0000;
            host_port_ad_oe_n <= 16'hffff;
            host_port_ack_n <= 1'b1;
        end else begin
            hp_state_q <= hp_state_d;
            hp_addr_q <= hp_addr_d;
            host_port_ad_out <= hp_out_d;
            host_port_ad_oe_n <= hp_oe_n_d;
            host_port_ack_n <= hp_ack_n_d;
        end
    end

    dspmx_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .addr(hp_addr_q),
        .wdata(host_port_ad_in),
        .rdata(ram_rdata)
    );

    // ---------------- checks
    pins_released_a: assert property (@(posedge clk) disable iff (!arst_n)
        !mode_valid_q |=> gp_io_oe_n == 8'hff) else $error("gp pins driven before mode capture");
    mode_frozen_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode_valid_q |=> $stable(mode_q) && $stable(host_mode)) else $error("mode changed while running");
    mode_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(mode_valid_q) |-> mode_q == $past(mode_pins)) else $error("mode not taken at release");
    full_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
        acc && !host_mode |=> ext_addr_out == $past(req_addr)) else $error("full mode address wrong");
    host_narrow_a: assert property (@(posedge clk) disable iff (!arst_n)
        host_mode |=> ext_addr_out[13:1] == 13'h0000 && ext_data_oe_n[7:0] == 8'hff)
        else $error("host mode drove a released pin");
    host_read_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
        hp_state_q == dspmx_pkg::HP_IDLE && hp_on && !host_addr_latch && !host_rd_en_n
        |-> ##2 !host_port_ack_n && host_port_ad_oe_n == 16'h0000) else $error("host read not acknowledged");
    edge_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode_valid_q && !gp_dir_q[4] && !gp_io_in[4] && irq_prev_q[0] |=> irq_pend_q[0])
        else $error("edge interrupt missed");
    level_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        !gp_dir_q[5] && gp_io_in[5] |=> !irq_pend_q[1]) else $error("level interrupt held without pin");
    flag_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode_valid_q && gp_dir_q[5] && !gp_out_q[5] |=> irq_pend_q[1]) else $error("output flag did not interrupt");
    bus_grant_a: assert property (@(posedge clk) disable iff (!arst_n)
        !bus_req_n && !core_req.rd && !core_req.wr |=> !bus_grant_n && ext_bus_oe_n)
        else $error("bus request not granted");
    io_select_a: assert property (@(posedge clk) disable iff (!arst_n)
        acc && req_space == dspmx_pkg::SP_IO |=> !io_space_sel_n && data_space_sel_n)
        else $error("wrong space select");
    flag_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl_q[dspmx_pkg::CTRL_SP1_ALT] |=> sp1_dt_out == $past(gp_out_q[8])) else $error("flag out not on pin");
    pd_release_a: assert property (@(posedge clk) disable iff (!arst_n)
        !powerdown_req |=> !powerdown_ack) else $error("power-down ack without request");
endmodule // dspmx_top

/* File: hw/dspmx_pkg.sv */
// shared constants and types for the dsp pin-function mux
package dspmx_pkg;
    // widths
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned DATA_W = 24;
    localparam int unsigned HP_W = 16;
    localparam int unsigned GPIO_W = 8;
    localparam int unsigned N_IRQ = 6;
    localparam int unsigned HP_AW = 6;
    localparam int unsigned HP_DEPTH = 64;
    localparam int unsigned PADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_GPIO_DIR = 12'h004;
    localparam logic [11:0] OFS_GPIO_OUT = 12'h008;
    localparam logic [11:0] OFS_GPIO_IN = 12'h00c;
    localparam logic [11:0] OFS_INTERRUPT_MASK_REG = 12'h010;
    localparam logic [11:0] OFS_IRQ_PEND = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;

    // field positions
    localparam int unsigned CTRL_SP1_ALT = 0;
    localparam int unsigned CTRL_IRQ7_EDGE = 1;
    localparam int unsigned CTRL_SPIRQ0_EDGE = 2;
    localparam int unsigned CTRL_SPIRQ1_EDGE = 3;
    localparam int unsigned CTRL_CMB_LSB = 8;
    localparam int unsigned GPOUT_FLAG_BIT = 8;
    localparam int unsigned GPIN_FLAG_BIT = 8;
    localparam int unsigned STAT_HOST = 0;
    localparam int unsigned STAT_GRANT = 1;
    localparam int unsigned STAT_PDACK = 2;
    localparam int unsigned STAT_VALID = 3;
    localparam int unsigned STAT_PINS_LSB = 4;
    localparam int unsigned MODE_HOST_BIT = 2;
    localparam int unsigned IRQ_PIN_LSB = 4;

    // reset values
    localparam logic [11:0] CTRL_RST = 12'h300;
    localparam logic [8:0] GPIO_DIR_RST = 9'h000;
    localparam logic [8:0] GPIO_OUT_RST = 9'h1ff;
    localparam logic [5:0] INTERRUPT_MASK_REG_RST = 6'h00;

    typedef enum logic [1:0] {
        SP_DATA = 2'h0,
        SP_PROG = 2'h1,
        SP_BYTE = 2'h2,
        SP_IO = 2'h3
    } dspmx_space_t;

    // core-side external memory request
    typedef struct packed {
        logic rd;
        logic wr;
        dspmx_space_t space;
        logic [13:0] addr;
        logic [7:0] baddr_hi;
        logic [23:0] wdata;
    } dspmx_mem_req_t;

    typedef enum logic [2:0] {
        HP_IDLE = 3'h1,
        HP_READ = 3'h2,
        HP_ACK = 3'h4
    } dspmx_hp_state_t;
endpackage

/* File: hw/dspmx_ram.sv */
// small host-port memory with registered read data
`timescale 1ns/100ps
module dspmx_ram (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [dspmx_pkg::HP_AW-1:0] addr,
    input wire logic [dspmx_pkg::HP_W-1:0] wdata,
    // read port
    output logic [dspmx_pkg::HP_W-1:0] rdata
);
    logic [dspmx_pkg::HP_W-1:0] mem [dspmx_pkg::HP_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // dspmx_ram

/* File: testbench/dspmx_ext_mem.sv */
// behavioural external memory on the far side of the pin mux
`timescale 1ns/100ps
module dspmx_ext_mem (
    // bus pins from the device
    input wire logic [13:0] ext_addr_out,
    input wire logic combined_sel_n,
    input wire logic mem_rd_n,
    // data back to the device
    output logic [23:0] ext_data_in
);
    // undriven bus shows an inverted pattern so a stale value never passes for data
    assign ext_data_in = !mem_rd_n ? {combined_sel_n, 9'h0a5, ext_addr_out}
                                   : {~combined_sel_n, 9'h15a, ~ext_addr_out};
endmodule // dspmx_ext_mem

/* File: testbench/test_dsp_pin_function_mux.sv */
// self-checking bench for the dsp pin-function mux
`timescale 1ns/100ps
module test_dsp_pin_function_mux;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, host_mode, ext_bus_oe_n, mem_rd_n, mem_wr_n, powerdown_ack;
    logic [7:0] gp_io_in = 8'hff, gp_io_out, gp_io_oe_n;
    dspmx_pkg::dspmx_mem_req_t core_req = '0;
    logic [5:0] irq_req;
    logic [23:0] core_rdata;
    logic sp1_rfs = 1'b1, sp1_tfs = 1'b1, sp1_dr = 1'b1, sp1_dt_out, core_sp1_dr;
    logic [13:0] ext_addr_out;
    logic [23:0] ext_data_in, ext_data_out, ext_data_oe_n;
    logic data_space_sel_n, prog_space_sel_n, byte_space_sel_n, io_space_sel_n, combined_sel_n;
    logic bus_req_n = 1'b1, bus_grant_n, bus_grant_hung_n, host_port_ack_n, powerdown_req = 1'b0;
    logic [15:0] host_port_ad_in = 16'h0, host_port_ad_out, host_port_ad_oe_n;
    logic host_addr_latch = 1'b0, host_port_sel_n = 1'b1, host_rd_en_n = 1'b1, host_wr_en_n = 1'b1;
    int fails = 0;
    int comparisons = 0;
    wire [5:0] w = {pready, powerdown_ack, ~bus_grant_n, ~host_port_ack_n, irq_req[1], irq_req[0]};

    dspmx_top dut (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .gp_io_in, .gp_io_out, .gp_io_oe_n, .sp1_rfs_in(sp1_rfs), .sp1_tfs_in(sp1_tfs), .sp1_dr_in(sp1_dr),
        .sp1_dt_out, .core_sp1_dt(1'b1), .core_sp1_dr, .core_req, .core_rdata, .irq_req,
        .host_mode, .ext_addr_out, .ext_data_in, .ext_data_out, .ext_data_oe_n, .ext_bus_oe_n,
        .data_space_sel_n, .prog_space_sel_n, .byte_space_sel_n, .io_space_sel_n, .combined_sel_n,
        .mem_rd_n, .mem_wr_n, .bus_req_n, .bus_grant_n, .bus_grant_hung_n, .host_port_ad_in,
        .host_port_ad_out, .host_port_ad_oe_n, .host_addr_latch, .host_port_sel_n, .host_rd_en_n,
        .host_wr_en_n, .host_port_ack_n, .powerdown_req, .powerdown_ack
    );
    dspmx_ext_mem ext_mem (.ext_addr_out, .combined_sel_n, .mem_rd_n, .ext_data_in);

    initial forever #5 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // bounded wait for one watched output to reach a level
    task automatic wt(input int k, input logic v);
        int n;
        n = 0;
        while (w[k] !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 30) begin
                chk(32'(k), 32'hff);
                finish_test();
            end
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready and read data are taken at the edge that ends the access
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 30);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'hff);
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // straps stay on the pins past the first edge after release
    task automatic rst(input logic [2:0] straps);
        @(posedge clk);
        arst_n <= 1'b0;
        gp_io_in <= {5'h1f, straps};
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        gp_io_in <= 8'hff;
        #1;
        chk(host_mode, straps[2]);
        chk(gp_io_oe_n, 8'hff);
    endtask
    task automatic t_regs();
        apb(1'b0, dspmx_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'(dspmx_pkg::CTRL_RST));
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b0, dspmx_pkg::OFS_STATUS, 32'h0);
        chk(rd[6:0], 7'h08);
    endtask
    task automatic t_mem();
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            core_req <= '{1'b1, 1'b0, dspmx_pkg::dspmx_space_t'(s), 14'h2a5c, 8'hc3, 24'h0};
            @(posedge clk);
            core_req.rd <= 1'b0;
            #1;
            chk({data_space_sel_n, prog_space_sel_n, byte_space_sel_n, io_space_sel_n}, 4'(~(4'h8 >> s)));
            chk({combined_sel_n, mem_rd_n, mem_wr_n}, {s > 1, 2'h1});
            chk(ext_addr_out, 14'h2a5c);
            if (s == 2) chk(ext_data_out[23:16], 8'hc3);
            @(posedge clk);
            #1;
            chk(core_rdata, {s > 1, 9'h0a5, 14'h2a5c});
        end
        @(posedge clk);
        core_req.wr <= 1'b1;
        core_req.wdata <= 24'h5b17e9;
        @(posedge clk);
        core_req.wr <= 1'b0;
        #1;
        chk({mem_rd_n, mem_wr_n, ext_data_out}, {2'h2, 24'h5b17e9});
        chk(ext_data_oe_n, 24'h0);
    endtask
    task automatic t_irq();
        apb(1'b1, dspmx_pkg::OFS_INTERRUPT_MASK_REG, 32'h3);
        @(posedge clk);
        gp_io_in[4] <= 1'b0;
        wt(0, 1'b1);
        @(posedge clk);
        gp_io_in[4] <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(irq_req[0], 1'b1);
        apb(1'b1, dspmx_pkg::OFS_IRQ_PEND, 32'h1);
        wt(0, 1'b0);
        apb(1'b1, dspmx_pkg::OFS_GPIO_DIR, 32'h20);
        apb(1'b1, dspmx_pkg::OFS_GPIO_OUT, 32'h1df);
        wt(1, 1'b1);
        chk({gp_io_oe_n, gp_io_out}, 16'hdfdf);
        apb(1'b1, dspmx_pkg::OFS_GPIO_OUT, 32'h1ff);
        wt(1, 1'b0);
    endtask
    task automatic t_sp1();
        chk({sp1_dt_out, core_sp1_dr}, 2'h3);
        apb(1'b1, dspmx_pkg::OFS_CTRL, 32'h305);
        apb(1'b1, dspmx_pkg::OFS_INTERRUPT_MASK_REG, 32'h33);
        apb(1'b1, dspmx_pkg::OFS_GPIO_OUT, 32'h0ff);
        @(posedge clk);
        sp1_rfs <= 1'b0;
        sp1_tfs <= 1'b0;
        sp1_dr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({irq_req[5:4], sp1_dt_out, core_sp1_dr}, 4'hc);
        apb(1'b0, dspmx_pkg::OFS_GPIO_IN, 32'h0);
        chk(rd, 32'h0ff);
        @(posedge clk);
        sp1_rfs <= 1'b1;
        sp1_tfs <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(irq_req[5:4], 2'h1);
    endtask
    task automatic t_arb();
        @(posedge clk);
        bus_req_n <= 1'b0;
        wt(3, 1'b1);
        chk(ext_bus_oe_n, 1'b1);
        @(posedge clk);
        core_req.rd <= 1'b1;
        @(posedge clk);
        #1;
        chk({bus_grant_hung_n, io_space_sel_n, mem_rd_n}, 3'h3);
        @(posedge clk);
        core_req.rd <= 1'b0;
        bus_req_n <= 1'b1;
        wt(3, 1'b0);
        chk(bus_grant_hung_n, 1'b1);
        @(posedge clk);
        powerdown_req <= 1'b1;
        wt(4, 1'b1);
        @(posedge clk);
        powerdown_req <= 1'b0;
        wt(4, 1'b0);
    endtask
    task automatic t_host();
        @(posedge clk);
        host_port_sel_n <= 1'b0;
        host_addr_latch <= 1'b1;
        host_port_ad_in <= 16'h0005;
        @(posedge clk);
        host_addr_latch <= 1'b0;
        host_wr_en_n <= 1'b0;
        host_port_ad_in <= 16'hbeef;
        wt(2, 1'b1);
        @(posedge clk);
        host_wr_en_n <= 1'b1;
        host_port_ad_in <= 16'h4110;
        wt(2, 1'b0);
        @(posedge clk);
        host_addr_latch <= 1'b1;
        host_port_ad_in <= 16'h0005;
        @(posedge clk);
        host_addr_latch <= 1'b0;
        host_rd_en_n <= 1'b0;
        host_port_ad_in <= 16'hfffa;
        wt(2, 1'b1);
        chk({host_port_ad_out, host_port_ad_oe_n}, {16'hbeef, 16'h0});
        @(posedge clk);
        host_rd_en_n <= 1'b1;
        host_port_sel_n <= 1'b1;
        wt(2, 1'b0);
        chk(host_port_ad_oe_n, 16'hffff);
        @(posedge clk);
        core_req.rd <= 1'b1;
        core_req.addr <= 14'h3fff;
        @(posedge clk);
        core_req.rd <= 1'b0;
        #1;
        chk({ext_addr_out, ext_data_oe_n[7:0]}, {14'h1, 8'hff});
        @(posedge clk);
        #1;
        chk(core_rdata, {1'b1, 9'h0a5, 14'h0000});
    endtask

    initial begin
        rst(3'h0);
        t_regs();
        t_mem();
        t_irq();
        t_sp1();
        t_arb();
        rst(3'h4);
        t_host();
        finish_test();
    end
endmodule // test_dsp_pin_function_mux
